// File: rtl/fotc_consts.svh
// Constants for the fixed off-time current chopper.
// Assumes a 50 MHz system clock and a single bridge channel.
`ifndef FOTC_CONSTS_SVH
`define FOTC_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define FOTC_CLK_MHZ    50
`define FOTC_DEAD_NS    100
`define FOTC_DEAD_CYC   (((`FOTC_DEAD_NS) * (`FOTC_CLK_MHZ) + 999) / 1000)
`define FOTC_DEAD_LAST  3'(`FOTC_DEAD_CYC - 1)

// ----------------------------------------------------------------
// Internal clock divider and off counts
// ----------------------------------------------------------------
`define FOTC_DIV_LAST   4'hF
`define FOTC_OFF_LONG   3'h5
`define FOTC_OFF_SHORT  3'h3

// ----------------------------------------------------------------
// Synchroniser reset
// ----------------------------------------------------------------
// Pins as {drive_en, trip, thermal, off_sel}: hot and idle until seen
`define FOTC_PINS_SAFE  4'h2

`endif

// File: rtl/fotc_pkg.sv
// Types shared by the fixed off-time chopper.
// Assumes the constants header is compiled alongside.
`default_nettype none

package fotc_pkg;

  // ----------------------------------------------------------------
  // Chopper states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    FOTC_IDLE     = 5'h01,  // Bridge fully off
    FOTC_DEAD_ON  = 5'h02,  // Gap before drive-on
    FOTC_ON       = 5'h04,  // Drive-on, watching comparator
    FOTC_DEAD_OFF = 5'h08,  // Gap before short brake
    FOTC_BRAKE    = 5'h10   // Short brake, counting off time
  } fotc_state_t;

  // ----------------------------------------------------------------
  // Gate drives of the two legs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hs_a;  // Leg A high side
    logic ls_a;  // Leg A low side
    logic hs_b;  // Leg B high side
    logic ls_b;  // Leg B low side
  } fotc_bridge_t;

  // ----------------------------------------------------------------
  // Synchronised pin inputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic drive_en;  // Channel drive request
    logic trip;      // Current comparator trip
    logic thermal;   // Thermal shutdown flag
    logic off_sel;   // Chop-off count select
  } fotc_pins_t;

endpackage

`default_nettype wire

// File: rtl/fotc_chopper.sv
// Fixed off-time current chopper for one H-bridge channel.
// Assumes rst is the undervoltage lockout and pins are asynchronous.
`include "fotc_consts.svh"
`default_nettype none

module fotc_chopper (
  input  wire logic                  clk_sys,  // 50 MHz system clock
  input  wire logic                  rst,      // Undervoltage reset, async high
  input  wire fotc_pkg::fotc_pins_t  pins,     // Asynchronous control pins
  output var  fotc_pkg::fotc_bridge_t bridge,  // Gate drives
  output var  logic                  bias_en,  // Output bias enable
  output var  logic                  off_active // High during off period
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fotc_pkg::fotc_pins_t   sync1_reg;     // First synchroniser stage
  fotc_pkg::fotc_pins_t   sync2_reg;     // Second synchroniser stage
  logic [3:0]             div_reg;       // Internal clock divider
  logic [3:0]             div_next;      // Divider next value
  logic                   tick;          // Internal clock rising edge
  fotc_pkg::fotc_state_t  state_reg;     // Chopper state
  fotc_pkg::fotc_state_t  state_next;    // State next value
  logic [2:0]             dead_reg;      // Dead-time counter
  logic [2:0]             dead_next;     // Dead-time next value
  logic [2:0]             off_cnt_reg;   // Off-period edge counter
  logic [2:0]             off_cnt_next;  // Off counter next value
  logic [2:0]             lim_reg;       // Edges in this off period
  logic [2:0]             lim_next;      // Limit next value
  fotc_pkg::fotc_bridge_t bridge_next;   // Gate drive next value
  logic                   bias_next;     // Bias next value
  logic                   off_next;      // Off flag next value

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  // Two stages; only the second one is read by logic
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // Treat the die as hot until a cool reading has passed both
      // stages, so bias cannot blip on while the thermal pin is high
      sync1_reg <= `FOTC_PINS_SAFE;
      sync2_reg <= `FOTC_PINS_SAFE;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Internal clock divider
  // ----------------------------------------------------------------
  // Free running, so the first off edge falls anywhere in the period;
  // off time therefore varies by up to one internal clock
  always_comb begin
    tick     = (div_reg == `FOTC_DIV_LAST);
    div_next = tick ? 4'h0 : div_reg + 4'h1;
  end

  // Divider register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ----------------------------------------------------------------
  // Chopper sequence
  // ----------------------------------------------------------------
  // Next state, counters and gate drives
  always_comb begin
    state_next   = state_reg;
    dead_next    = dead_reg;
    off_cnt_next = off_cnt_reg;
    lim_next     = lim_reg;
    if (sync2_reg.thermal || !sync2_reg.drive_en) begin
      // Thermal flag or no request: park the bridge off
      state_next   = fotc_pkg::FOTC_IDLE;
      dead_next    = 3'h0;
      off_cnt_next = 3'h0;
    end else begin
      unique case (state_reg)
        fotc_pkg::FOTC_IDLE: begin
          // Start with a gap before the first drive-on
          state_next = fotc_pkg::FOTC_DEAD_ON;
          dead_next  = 3'h0;
        end
        fotc_pkg::FOTC_DEAD_ON: begin
          dead_next = dead_reg + 3'h1;
          if (dead_reg == `FOTC_DEAD_LAST) begin
            state_next = fotc_pkg::FOTC_ON;
          end
        end
        fotc_pkg::FOTC_ON: begin
          // Trip turns the high side off; off count starts here
          if (sync2_reg.trip) begin
            state_next   = fotc_pkg::FOTC_DEAD_OFF;
            dead_next    = 3'h0;
            off_cnt_next = 3'h0;
            lim_next     = sync2_reg.off_sel ? `FOTC_OFF_SHORT
                                             : `FOTC_OFF_LONG;
          end
        end
        fotc_pkg::FOTC_DEAD_OFF: begin
          // Edges in the gap already count toward the off time
          dead_next = dead_reg + 3'h1;
          if (tick) begin
            off_cnt_next = off_cnt_reg + 3'h1;
          end
          if (dead_reg == `FOTC_DEAD_LAST) begin
            state_next = fotc_pkg::FOTC_BRAKE;
          end
        end
        fotc_pkg::FOTC_BRAKE: begin
          if (tick) begin
            if (off_cnt_reg == lim_reg) begin
              // Edge after the last counted one clears the counter
              off_cnt_next = 3'h0;
              state_next   = fotc_pkg::FOTC_DEAD_ON;
              dead_next    = 3'h0;
            end else begin
              off_cnt_next = off_cnt_reg + 3'h1;
            end
          end
        end
      endcase
    end
    // Gate drives follow the coming state; leg B low side stays on
    // across gaps so only leg A switches outside idle
    bridge_next = '0;
    unique case (state_next)
      fotc_pkg::FOTC_IDLE:     bridge_next = '0;
      fotc_pkg::FOTC_ON: begin
        bridge_next.hs_a = 1'b1;
        bridge_next.ls_b = 1'b1;
      end
      fotc_pkg::FOTC_BRAKE: begin
        bridge_next.ls_a = 1'b1;
        bridge_next.ls_b = 1'b1;
      end
      fotc_pkg::FOTC_DEAD_ON,
      fotc_pkg::FOTC_DEAD_OFF: bridge_next.ls_b = 1'b1;
    endcase
    bias_next = !sync2_reg.thermal;
    off_next  = (state_next == fotc_pkg::FOTC_DEAD_OFF) ||
                (state_next == fotc_pkg::FOTC_BRAKE);
  end

  // Sequence registers; undervoltage reset forces all drives off
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg   <= fotc_pkg::FOTC_IDLE;
      dead_reg    <= 3'h0;
      off_cnt_reg <= 3'h0;
      lim_reg     <= `FOTC_OFF_LONG;
      bridge      <= '0;
      bias_en     <= 1'b0;
      off_active  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      dead_reg    <= dead_next;
      off_cnt_reg <= off_cnt_next;
      lim_reg     <= lim_next;
      bridge      <= bridge_next;
      bias_en     <= bias_next;
      off_active  <= off_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_on_to_gap;
    @(posedge clk_sys) disable iff (rst)
      bridge.hs_a |=> (bridge.hs_a || !bridge.ls_a);
  endproperty
  a_on_to_gap: assert property (p_on_to_gap)
    else $error("Drive-on went straight to brake");

  property p_dead_off;
    @(posedge clk_sys) disable iff (rst)
      $fell(bridge.hs_a) |-> !bridge.ls_a [*5];
  endproperty
  a_dead_off: assert property (p_dead_off)
    else $error("Brake applied inside dead time");

  property p_dead_on;
    @(posedge clk_sys) disable iff (rst)
      $rose(bridge.hs_a) |-> !$past(bridge.ls_a) && !$past(bridge.ls_a, 5);
  endproperty
  a_dead_on: assert property (p_dead_on)
    else $error("Drive-on followed brake with no gap");

  property p_count_on_tick;
    @(posedge clk_sys) disable iff (rst)
      ($changed(off_cnt_reg) && off_cnt_reg != 3'h0) |-> $past(tick);
  endproperty
  a_count_on_tick: assert property (p_count_on_tick)
    else $error("Off counter moved without internal clock edge");

  property p_limit_select;
    @(posedge clk_sys) disable iff (rst)
      $rose(off_active) |->
        lim_reg == ($past(sync2_reg.off_sel) ? `FOTC_OFF_SHORT : `FOTC_OFF_LONG);
  endproperty
  a_limit_select: assert property (p_limit_select)
    else $error("Off count does not match select bit");

  property p_count_bound;
    @(posedge clk_sys) disable iff (rst)
      off_active |-> (off_cnt_reg <= lim_reg) &&
                     (lim_reg == `FOTC_OFF_SHORT || lim_reg == `FOTC_OFF_LONG);
  endproperty
  a_count_bound: assert property (p_count_bound)
    else $error("Off counter beyond its limit");

  property p_wrap;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == fotc_pkg::FOTC_BRAKE && tick && off_cnt_reg == lim_reg &&
       sync2_reg.drive_en && !sync2_reg.thermal)
        |=> (off_cnt_reg == 3'h0) && !off_active;
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("Off period did not end after last edge");

  property p_trip;
    @(posedge clk_sys) disable iff (rst)
      (state_reg == fotc_pkg::FOTC_ON && sync2_reg.trip && sync2_reg.drive_en &&
       !sync2_reg.thermal)
        |=> !bridge.hs_a && off_active && off_cnt_reg == 3'h0;
  endproperty
  a_trip: assert property (p_trip)
    else $error("Trip did not start the off period");

  property p_thermal;
    @(posedge clk_sys) disable iff (rst)
      sync2_reg.thermal |=> !bias_en && bridge == '0;
  endproperty
  a_thermal: assert property (p_thermal)
    else $error("Bridge driven during thermal shutdown");

  property p_resume;
    @(posedge clk_sys) disable iff (rst)
      ($fell(off_active) && bridge.ls_b) |-> ##[1:6] (bridge.hs_a || !bridge.ls_b);
  endproperty
  a_resume: assert property (p_resume)
    else $error("Drive-on not resumed after off period");

endmodule

`default_nettype wire

// File: verification/fotc_partner.sv
// Behavioural coil and current comparator facing the chopper's gate drives.
// Assumes high-active gate drives and the single chopper clock domain.
`default_nettype none

module fotc_partner (
  input  wire logic                   clk_sys,  // System clock
  input  wire logic                   rst,      // Undervoltage reset
  input  wire fotc_pkg::fotc_bridge_t bridge,   // Gate drives seen
  input  wire logic                   fast,     // Steep current rise
  output var  logic                   trip      // Comparator output
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Coil current and comparator
  // ----------------------------------------------------------------
  localparam int LIMIT = 40;  // Limit of sense_resistor_voltage, in steps
  int level;                  // Coil current, arbitrary steps

  // Ramp while driven, decay otherwise; decay is slow so brake never ends early
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      level <= 0;
    end else if (bridge.hs_a && bridge.ls_b) begin
      level <= level + (fast ? 8 : 1);
    end else if (level > 0) begin
      level <= level - 1;
    end
  end

  // Trips once the voltage on current_sense_resistor reaches the limit
  assign trip = (level >= LIMIT);
endmodule

`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the fixed off-time chopper.
// Assumes the coil model drives the trip pin; all other pins come from here.
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic                   clk_sys = 1'b0;  // 50 MHz clock
  logic                   rst = 1'b1;      // Undervoltage reset
  logic                   drive_en = 1'b1; // Held high except for a three-cycle drop in t_off
  logic                   thermal = 1'b0;  // Thermal flag
  logic                   off_sel = 1'b0;  // Off count select
  logic                   fast = 1'b0;     // Coil speed in the model
  logic                   trip;            // From the coil model
  fotc_pkg::fotc_pins_t   pins;            // Packed pin bundle
  fotc_pkg::fotc_bridge_t bridge;          // Gate drives
  logic                   bias_en;         // Bias enable
  logic                   off_active;      // Off period flag
  int                     n_errors = 0;    // Mismatches
  int                     n_checks = 0;    // Comparisons

  assign pins = {drive_en, trip, thermal, off_sel};
  always #10 clk_sys = ~clk_sys;

  fotc_chopper u_fotc_chopper (.clk_sys(clk_sys), .rst(rst), .pins(pins), .bridge(bridge),
                               .bias_en(bias_en), .off_active(off_active));
  fotc_partner u_fotc_partner (.clk_sys(clk_sys), .rst(rst), .bridge(bridge), .fast(fast),
                               .trip(trip));

  // Leg A must never conduct from rail to rail, leg B never switches high
  // Sampled on the falling edge, where registered drives have settled
  always @(negedge clk_sys) begin
    if (!rst) begin
      `CHK("leg_a_overlap", 1'b0, bridge.hs_a & bridge.ls_a)
      `CHK("hs_b", 1'b0, bridge.hs_b)
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Same small offset after each edge for driving and sampling alike
  task automatic step;
    @(posedge clk_sys);
    #2;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return bridge.hs_a;
      1: return bridge.ls_a;
      default: return bias_en;
    endcase
  endfunction

  // Bounded wait for a drive to reach a level; n counts the edges taken
  task automatic wait_bit(input int s, input logic v, output int n);
    n = 0;
    while (pick(s) !== v) begin
      step();
      n++;
      if (n > 3000) begin
        n_errors++;
        $display("[ERR] wait_%0d expected %0h seen %0h", s, v, pick(s));
        conclude();
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    int n;
    rst = 1'b1;
    repeat (4) step();
    `CHK("rst_bridge", 4'h0, bridge)
    `CHK("rst_bias", 1'b0, bias_en)
    `CHK("rst_off", 1'b0, off_active)
    rst = 1'b0;
    wait_bit(2, 1'b1, n);
    `CHK("bias_delay", 3, n)
    `CHK("bias_up", 1'b1, bias_en)
  endtask

  // One full chop: trip, gap, brake of the selected length, gap, drive again
  task automatic t_chop(input logic sel, input logic f);
    int n;
    int m;
    int lim;
    off_sel = sel;
    fast = f;
    lim = sel ? 3 : 5;
    wait_bit(0, 1'b1, n);
    `CHK("on_ls_b", 1'b1, bridge.ls_b)
    wait_bit(0, 1'b0, n);
    `CHK("off_flag", 1'b1, off_active)
    wait_bit(1, 1'b1, n);
    `CHK("gap_off", 5, n)
    `CHK("brake_ls_b", 1'b1, bridge.ls_b)
    wait_bit(1, 1'b0, m);
    m = m + 5;
    // First tick may come after any part of a divider period
    `CHK("off_len", 1'b1, m > 16 * lim && m <= 16 * lim + 16)
    `CHK("off_end", 1'b0, off_active)
    wait_bit(0, 1'b1, n);
    `CHK("gap_on", 5, n)
  endtask

  // Thermal flag (0) or channel disable (1) must drop all gates
  task automatic t_off(input int which);
    int n;
    if (which == 0) begin
      thermal = 1'b1;
    end else begin
      drive_en = 1'b0;
    end
    repeat (3) step();
    `CHK("off_bridge", 4'h0, bridge)
    if (which == 0) begin
      `CHK("off_bias", 1'b0, bias_en)
    end
    thermal = 1'b0;
    drive_en = 1'b1;
    wait_bit(2, 1'b1, n);
  endtask

  initial begin
    t_reset();
    t_chop(1'b0, 1'b0);
    t_chop(1'b0, 1'b1);
    t_chop(1'b1, 1'b0);
    t_chop(1'b1, 1'b1);
    t_off(0);
    t_chop(1'b0, 1'b0);
    t_off(1);
    t_chop(1'b1, 1'b1);
    t_reset();
    t_chop(1'b0, 1'b1);
    conclude();
  end
endmodule

`default_nettype wire
